// ---- via_device.sv ----
// Video input accelerator: device end with FIFO, line buffers, scaler and
// colour converter. Assumes a host on via_if and a display pipe on the user side.
`timescale 1ns/1ps
`include "via_defines.svh"

module via_fifo #(
   parameter int W = 8,
   parameter int D = `VIA_FIFO_DEPTH
) (
   input  wire logic                 core_clk_i,
   input  wire logic                 nrst_i,
   input  wire logic [W-1:0]         in_data_i,
   input  wire logic                 in_valid_i,
   output logic                      in_ready_o,
   output logic [W-1:0]              out_data_o,
   output logic                      out_valid_o,
   input  wire logic                 out_ready_i,
   output logic [$clog2(D):0]        count_o
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem [D];
   logic [AW-1:0] wp;
   logic [AW-1:0] rp;
   wire push = in_valid_i & in_ready_o;
   wire pop  = out_valid_o & out_ready_i;

   assign in_ready_o  = (count_o != (AW+1)'(D));
   assign out_valid_o = (count_o != '0);
   assign out_data_o  = mem[rp];

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wp      <= '0;
         rp      <= '0;
         count_o <= '0;
      end else begin
         wp      <= push ? AW'((wp == AW'(D-1)) ? 0 : wp + 1'b1) : wp;
         rp      <= pop ? AW'((rp == AW'(D-1)) ? 0 : rp + 1'b1) : rp;
         count_o <= count_o + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem[wp] <= in_data_i;
      end
   end
endmodule

module via_device (
   input  wire logic        core_clk_i,
   input  wire logic        nrst_i,
   via_if.device            vif,
   input  wire logic [31:0] reg_addr_i,
   input  wire logic [3:0]  reg_be_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic [31:0] reg_wdata_i,
   output logic [31:0]      reg_rdata_o,
   input  wire logic        bar_wr_i,
   input  wire logic [31:0] bar_wdata_i,
   output logic [31:0]      bar_rdata_o,
   input  wire logic        line_start_i,
   input  wire logic        pix_req_i,
   output logic [23:0]      rgb_o,
   output logic             rgb_valid_o,
   input  wire logic [23:0] gfx_pixel_i,
   output logic [15:0]      gfx_pixel16_o
);
   localparam int NW = `VIA_LB_WORDS;
   localparam int FD = `VIA_FIFO_DEPTH;

   logic [31:0] cfg;
   logic [31:0] scl;
   logic [2:0]  full;
   logic [1:0]  wbuf;
   logic [1:0]  rbuf;
   logic [8:0]  wc;
   logic [1:0]  bc;
   logic [7:0]  b0;
   logic [7:0]  b1;
   logic [7:0]  b2;
   logic [22:0] acc_x;
   logic [12:0] acc_y;
   logic        dth;
   logic [31:0] lbuf [`VIA_LB_COUNT*NW];

   // ----------------------------------------------------------------------------
   // Register window
   // ----------------------------------------------------------------------------
   wire [11:0] off   = reg_addr_i[11:0];
   wire        hit   = reg_addr_i[31:`VIA_WIN_LSB] == bar_rdata_o[31:`VIA_WIN_LSB];
   wire        fullw = reg_be_i == `VIA_FULL_BE;
   wire        wr_ok = reg_wr_i & hit & fullw;
   wire        rd_ok = reg_rd_i & hit & fullw;
   wire [4:0]  fcnt;
   wire [31:0] stat  = {20'h0, fcnt, full, wbuf, rbuf};
   wire [31:0] rd_mux = (off == `VIA_CFG_OFF)  ? cfg :
                        (off == `VIA_SCL_OFF)  ? {2'b00, scl[29:16], 2'b00, scl[13:0]} :
                        (off == `VIA_STAT_OFF) ? stat : 32'h0;

   // ----------------------------------------------------------------------------
   // Port intake
   // ----------------------------------------------------------------------------
   wire       en     = cfg[`VIA_B_ENABLE];
   wire       wide   = cfg[`VIA_B_WIDE16];
   wire       tick   = vif.video_port_clock;
   // Early ready is unsafe together with fast timing, so fast timing wins
   wire       early  = cfg[`VIA_B_EARLY] & ~cfg[`VIA_B_HSPEED];
   wire       f_in_rdy;
   wire       take   = tick & vif.video_byte_valid & vif.line_buffer_ready & f_in_rdy;
   wire       room   = fcnt <= 5'(FD-2);
   wire       next_ready = en & ~full[wbuf] & room;
   wire [7:0] pbyte;
   wire       pvalid;
   wire       pready = ~full[wbuf];

   via_fifo #(.W(8), .D(FD)) via_fifo_inst (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .in_data_i  (vif.video_byte_bus),
      .in_valid_i (take),
      .in_ready_o (f_in_rdy),
      .out_data_o (pbyte),
      .out_valid_o(pvalid),
      .out_ready_i(pready),
      .count_o    (fcnt)
   );

   // ----------------------------------------------------------------------------
   // Byte ordering into {Y0,U,Y1,V}
   // ----------------------------------------------------------------------------
   wire [1:0] fmt = cfg[`VIA_F_FMT];
   wire [1:0] ef  = ~wide ? fmt :
                    (fmt == 2'b01) ? 2'(via_pkg::VIA_FMT_YUYV) :
                    (fmt == 2'b10) ? 2'(via_pkg::VIA_FMT_Y1VU) : 2'(via_pkg::VIA_FMT_UYVY);
   wire [31:0] word =
      (ef == 2'(via_pkg::VIA_FMT_UYVY)) ? {b1, b0, pbyte, b2} :
      (ef == 2'(via_pkg::VIA_FMT_Y1VU)) ? {b2, pbyte, b0, b1} :
      (ef == 2'(via_pkg::VIA_FMT_YUYV)) ? {b0, b1, b2, pbyte} : {b0, pbyte, b2, b1};
   wire [8:0] len    = {cfg[`VIA_B_LEN_MSB], cfg[`VIA_F_LEN]};
   wire       pop    = pvalid & pready;
   wire       wword  = pop & (bc == 2'd3);
   wire       ldone  = wword & ((wc + 9'd1) >= len);
   wire [1:0] wnext  = (wbuf == 2'd2) ? 2'd0 : wbuf + 2'd1;
   wire [1:0] rnext  = (rbuf == 2'd2) ? 2'd0 : rbuf + 2'd1;

   // ----------------------------------------------------------------------------
   // Scaler DDA and filters
   // ----------------------------------------------------------------------------
   wire        gv     = cfg[`VIA_B_GV_SEL];
   wire [13:0] step_x = gv ? `VIA_UNITY : scl[`VIA_F_XSCL];
   wire [13:0] step_y = gv ? `VIA_UNITY : scl[`VIA_F_YSCL];
   wire [14:0] sum_y  = {2'b00, acc_y} + {1'b0, step_y};
   wire        vadv   = line_start_i & (sum_y[14:13] != 2'b00);
   wire [9:0]  pix    = acc_x[22:13];
   wire [9:0]  pix1   = pix + 10'd1;
   wire [2:0]  hph    = acc_x[12:10];
   wire [2:0]  vph    = acc_y[12:10];
   wire [31:0] wt0    = lbuf[idx(rbuf, pix[9:1])];
   wire [31:0] wt1    = lbuf[idx(rbuf, pix1[9:1])];
   wire [31:0] wb0    = lbuf[idx(rnext, pix[9:1])];
   wire [31:0] wb1    = lbuf[idx(rnext, pix1[9:1])];
   wire        hf     = cfg[`VIA_B_HFILT];
   wire        vf     = cfg[`VIA_B_VFILT];
   wire [7:0]  yt     = hf ? blend(ysel(wt0, pix[0]), ysel(wt1, pix1[0]), hph)
                           : ysel(wt0, pix[0]);
   wire [7:0]  yb     = hf ? blend(ysel(wb0, pix[0]), ysel(wb1, pix1[0]), hph)
                           : ysel(wb0, pix[0]);
   wire [7:0]  yf     = vf ? blend(yt, yb, vph) : yt;
   wire [7:0]  uf     = vf ? blend(wt0[23:16], wb0[23:16], vph) : wt0[23:16];
   wire [7:0]  vf8    = vf ? blend(wt0[7:0], wb0[7:0], vph) : wt0[7:0];

   // ----------------------------------------------------------------------------
   // Colour converter
   // ----------------------------------------------------------------------------
   wire [7:0] yc = clamp(yf, `VIA_Y_MIN, `VIA_Y_MAX);
   wire [7:0] uc = clamp(uf, `VIA_C_MIN, `VIA_C_MAX);
   wire [7:0] vc = clamp(vf8, `VIA_C_MIN, `VIA_C_MAX);
   wire signed [19:0] cy = $signed({12'h0, yc}) - `VIA_Y_OFS;
   wire signed [19:0] cu = $signed({12'h0, uc}) - `VIA_C_OFS;
   wire signed [19:0] cv = $signed({12'h0, vc}) - `VIA_C_OFS;
   wire signed [19:0] rs = `VIA_K_Y * cy + `VIA_K_RV * cv + `VIA_ROUND;
   wire signed [19:0] gs = `VIA_K_Y * cy - `VIA_K_GV * cv - `VIA_K_GU * cu + `VIA_ROUND;
   wire signed [19:0] bs = `VIA_K_Y * cy + `VIA_K_BU * cu + `VIA_ROUND;
   wire [23:0] rgb_csc = {sat8(rs), sat8(gs), sat8(bs)};
   wire [15:0] p565    = pix[0] ? wt0[15:0] : wt0[31:16];
   wire [23:0] rgb_raw = {p565[15:11], p565[15:13], p565[10:5], p565[10:9],
                          p565[4:0], p565[4:2]};
   wire [23:0] next_rgb = cfg[`VIA_B_CSC_BYP] ? rgb_raw : rgb_csc;

   // Ordered bias alternates per cycle to hide banding in wide mode
   wire [8:0] dr = {1'b0, gfx_pixel_i[23:16]} + {6'h0, dth, 2'b00};
   wire [8:0] dg = {1'b0, gfx_pixel_i[15:8]} + {7'h0, dth, 1'b0};
   wire [8:0] db = {1'b0, gfx_pixel_i[7:0]} + {6'h0, dth, 2'b00};
   wire [15:0] next_g16 = {dr[8] ? 5'h1f : dr[7:3], dg[8] ? 6'h3f : dg[7:2],
                           db[8] ? 5'h1f : db[7:3]};

   function automatic logic [10:0] idx(input logic [1:0] b, input logic [8:0] a);
      logic [8:0] ac;
      ac  = (a >= 9'(NW)) ? 9'(NW-1) : a;
      idx = 11'(b) * 11'(NW) + 11'(ac);
   endfunction

   function automatic logic [7:0] ysel(input logic [31:0] w, input logic odd);
      ysel = odd ? w[15:8] : w[31:24];
   endfunction

   function automatic logic [7:0] blend(input logic [7:0] a, input logic [7:0] b,
                                        input logic [2:0] ph);
      logic [11:0] s;
      s     = 12'(a) * 12'(`VIA_PHASES - {1'b0, ph}) + 12'(b) * 12'(ph);
      blend = s[10:3];
   endfunction

   function automatic logic [7:0] clamp(input logic [7:0] x, input logic [7:0] lo,
                                        input logic [7:0] hi);
      clamp = (x < lo) ? lo : (x > hi) ? hi : x;
   endfunction

   function automatic logic [7:0] sat8(input logic signed [19:0] x);
      sat8 = x[19] ? 8'h00 : (|x[18:16]) ? 8'hff : x[15:8];
   endfunction

   // ----------------------------------------------------------------------------
   // Registers and control state
   // ----------------------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cfg         <= `VIA_CFG_RST;
         scl         <= `VIA_SCL_RST;
         bar_rdata_o <= `VIA_BAR_RST;
         reg_rdata_o <= 32'h0;
      end else begin
         if (bar_wr_i) begin
            bar_rdata_o <= {bar_wdata_i[31:`VIA_WIN_LSB], 12'h000};
         end
         if (wr_ok && off == `VIA_CFG_OFF) begin
            cfg <= {1'b0, reg_wdata_i[30:27], 1'b0, reg_wdata_i[25:0]};
         end
         if (wr_ok && off == `VIA_SCL_OFF) begin
            scl <= reg_wdata_i;
         end
         if (reg_rd_i) begin
            reg_rdata_o <= rd_ok ? rd_mux : 32'h0;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         vif.line_buffer_ready <= 1'b0;
         full  <= 3'b000;
         wbuf  <= 2'd0;
         rbuf  <= 2'd0;
         wc    <= 9'd0;
         bc    <= 2'd0;
         b0    <= 8'h00;
         b1    <= 8'h00;
         b2    <= 8'h00;
      end else begin
         // Changed only off the transfer edge unless early ready is on, so it holds through it
         if (~tick | early) begin
            vif.line_buffer_ready <= next_ready;
         end
         full <= (full & ~(vadv ? 3'b001 << rbuf : 3'b000))
                 | (ldone ? 3'b001 << wbuf : 3'b000);
         if (vadv) begin
            rbuf <= rnext;
         end
         if (ldone) begin
            wbuf <= wnext;
         end
         if (pop) begin
            bc <= bc + 2'd1;
            b0 <= (bc == 2'd0) ? pbyte : b0;
            b1 <= (bc == 2'd1) ? pbyte : b1;
            b2 <= (bc == 2'd2) ? pbyte : b2;
         end
         if (wword) begin
            wc <= ldone ? 9'd0 : wc + 9'd1;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (wword) begin
         lbuf[idx(wbuf, wc)] <= word;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         acc_x         <= 23'h0;
         acc_y         <= 13'h0;
         dth           <= 1'b0;
         rgb_o         <= 24'h0;
         rgb_valid_o   <= 1'b0;
         gfx_pixel16_o <= 16'h0;
      end else begin
         dth         <= ~dth;
         rgb_valid_o <= pix_req_i;
         if (line_start_i) begin
            acc_x <= {cfg[`VIA_B_INIT_MSB], cfg[`VIA_F_INIT], 1'b0, 13'h0};
            acc_y <= sum_y[12:0];
         end else if (pix_req_i) begin
            acc_x <= acc_x + {9'h0, step_x};
         end
         if (pix_req_i) begin
            rgb_o <= next_rgb;
         end
         gfx_pixel16_o <= wide ? next_g16 : 16'h0;
      end
   end

endmodule

// ---- via_defines.svh ----
// Video input accelerator: offsets, field positions, reset values and constants.
// Assumes inclusion by bare name from the device, host and testbench files of the block.
`ifndef VIA_DEFINES_SVH
`define VIA_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets inside the 4 KB window
// ----------------------------------------------------------------------------
`define VIA_CFG_OFF      12'h000
`define VIA_SCL_OFF      12'h010
`define VIA_STAT_OFF     12'h040
`define VIA_WIN_LSB      12
`define VIA_CFG_RST      32'h0000_0000
`define VIA_SCL_RST      32'h0000_0000
`define VIA_BAR_RST      32'h0000_0000
`define VIA_FULL_BE      4'hf

// ----------------------------------------------------------------------------
// Configuration field positions
// ----------------------------------------------------------------------------
`define VIA_B_HSPEED     30
`define VIA_B_WIDE16     29
`define VIA_B_420        28
`define VIA_B_LEN_MSB    27
`define VIA_B_EARLY      25
`define VIA_B_INIT_MSB   24
`define VIA_F_INIT       23:16
`define VIA_F_LEN        15:8
`define VIA_B_VFILT      7
`define VIA_B_HFILT      6
`define VIA_B_CSC_BYP    5
`define VIA_B_GV_SEL     4
`define VIA_F_FMT        3:2
`define VIA_B_ENABLE     0
`define VIA_F_YSCL       29:16
`define VIA_F_XSCL       13:0

// ----------------------------------------------------------------------------
// Sizes and arithmetic constants
// ----------------------------------------------------------------------------
`define VIA_LB_WORDS     360
`define VIA_LB_COUNT     3
`define VIA_FIFO_DEPTH   16
`define VIA_UNITY        14'h2000
`define VIA_FRAC_BITS    13
`define VIA_PHASES       4'h8
`define VIA_K_Y          20'sd298
`define VIA_K_RV         20'sd409
`define VIA_K_GV         20'sd208
`define VIA_K_GU         20'sd100
`define VIA_K_BU         20'sd517
`define VIA_Y_OFS        20'sd16
`define VIA_C_OFS        20'sd128
`define VIA_ROUND        20'sd128
`define VIA_Y_MIN        8'h10
`define VIA_Y_MAX        8'heb
`define VIA_C_MIN        8'h10
`define VIA_C_MAX        8'hf0

`endif

// ---- via_pkg.sv ----
// Video input accelerator: shared types.
// Assumes via_defines.svh supplies the numeric constants.
package via_pkg;

   typedef enum logic [1:0] {
      VIA_FMT_UYVY = 2'b00,
      VIA_FMT_Y1VU = 2'b01,
      VIA_FMT_YUYV = 2'b10,
      VIA_FMT_YVYU = 2'b11
   } via_fmt_e;

   typedef enum logic [1:0] {
      VIA_H_IDLE = 2'b00,
      VIA_H_HOLD = 2'b01
   } via_hstate_e;

endpackage

// ---- via_if.sv ----
// Video input accelerator: byte-wide video port between host and device.
// Assumes both ends share core_clk_i; the port clock is a level they sample.
`timescale 1ns/1ps

interface via_if;
   logic       video_port_clock;
   logic       video_byte_valid;
   logic [7:0] video_byte_bus;
   logic       line_buffer_ready;

   modport host (
      output video_port_clock,
      output video_byte_valid,
      output video_byte_bus,
      input  line_buffer_ready
   );

   modport device (
      input  video_port_clock,
      input  video_byte_valid,
      input  video_byte_bus,
      output line_buffer_ready
   );
endinterface

// ---- via_host.sv ----
// Video input accelerator: host end driving the byte stream.
// Assumes the device end samples the port on core_clk_i.
`timescale 1ns/1ps
`include "via_defines.svh"

module via_host (
   input  wire logic       core_clk_i,
   input  wire logic       nrst_i,
   via_if.host             vif,
   input  wire logic [7:0] src_byte_i,
   input  wire logic       src_valid_i,
   output logic            src_ready_o
);

   via_pkg::via_hstate_e state;
   via_pkg::via_hstate_e next_state;

   // ----------------------------------------------------------------------------
   // Port clock and handshake
   // ----------------------------------------------------------------------------
   wire tick = vif.video_port_clock;
   wire done = tick & vif.video_byte_valid & vif.line_buffer_ready;
   wire load = src_ready_o & src_valid_i;

   always_comb begin
      next_state = state;
      case (state)
         via_pkg::VIA_H_IDLE: begin
            if (load) begin
               next_state = via_pkg::VIA_H_HOLD;
            end
         end
         via_pkg::VIA_H_HOLD: begin
            // Byte stays put until the device takes it
            if (done) begin
               next_state = via_pkg::VIA_H_IDLE;
            end
         end
         default: next_state = via_pkg::VIA_H_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state                <= via_pkg::VIA_H_IDLE;
         vif.video_port_clock <= 1'b0;
         vif.video_byte_valid <= 1'b0;
         vif.video_byte_bus   <= 8'h00;
         src_ready_o          <= 1'b0;
      end else begin
         state                <= next_state;
         vif.video_port_clock <= ~vif.video_port_clock;
         vif.video_byte_valid <= (next_state == via_pkg::VIA_H_HOLD);
         src_ready_o          <= (next_state == via_pkg::VIA_H_IDLE);
         if (load) begin
            vif.video_byte_bus <= src_byte_i;
         end
      end
   end

endmodule

// ---- via_assertions.sv ----
// Checker for the byte-wide video port between host and device ends.
// Assumes the testbench instantiates it beside the via_if instance.
`timescale 1ns/1ps

module via_assertions (
   input  wire logic       core_clk_i,
   input  wire logic       nrst_i,
   input  wire logic       video_port_clock,
   input  wire logic       video_byte_valid,
   input  wire logic [7:0] video_byte_bus,
   input  wire logic       line_buffer_ready
);
   wire take;

   assign take = video_byte_valid && line_buffer_ready && video_port_clock;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);

   // --------------------------------------------------------------------
   // Port properties
   // --------------------------------------------------------------------
   // Early-ready mode would break p_ready_edge; benches set bit 25 only with bit 30 also set
   // First edge after release would compare against the reset value
   property p_clk_toggle;
      $past(nrst_i) |-> video_port_clock != $past(video_port_clock);
   endproperty
   property p_ready_edge;
      $changed(line_buffer_ready) |-> !$past(video_port_clock);
   endproperty
   property p_ready_hold;
      $rose(line_buffer_ready) |=> line_buffer_ready;
   endproperty
   property p_valid_hold;
      video_byte_valid && !take |=> video_byte_valid && $stable(video_byte_bus);
   endproperty
   property p_drop_after_take;
      take |=> !video_byte_valid;
   endproperty
   property p_fall_cause;
      $fell(video_byte_valid) |-> $past(take);
   endproperty
   property p_bus_change;
      $changed(video_byte_bus) |-> $rose(video_byte_valid);
   endproperty
   property p_idle_start;
      !$past(nrst_i) |-> !video_byte_valid && !line_buffer_ready;
   endproperty

   a_clk_toggle: assert property (p_clk_toggle)
      else $error("port clock did not toggle");
   a_ready_edge: assert property (p_ready_edge)
      else $error("ready changed on a high port clock phase");
   a_ready_hold: assert property (p_ready_hold)
      else $error("ready pulse shorter than a port clock");
   a_valid_hold: assert property (p_valid_hold)
      else $error("byte or valid changed before acceptance");
   a_drop_after_take: assert property (p_drop_after_take)
      else $error("valid stayed after accepted byte");
   a_fall_cause: assert property (p_fall_cause)
      else $error("valid dropped without acceptance");
   a_bus_change: assert property (p_bus_change)
      else $error("bus advanced without new valid byte");
   a_idle_start: assert property (p_idle_start)
      else $error("port not idle after reset");

   c_take: cover property (take);
   c_ready_rise: cover property ($rose(line_buffer_ready));
   c_valid_fall: cover property ($fell(video_byte_valid));
endmodule

// ---- video_input_accelerator_tb.sv ----
// Testbench for both ends of the video input accelerator.
// Assumes via_if, via_host, via_device and via_assertions are compiled first.
`timescale 1ns/1ps
`include "via_defines.svh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fails++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end

module video_input_accelerator_tb;
   localparam logic [31:0] BASE = 32'h4000_0000;
   logic        core_clk_i, nrst_i, reg_wr_i, reg_rd_i, bar_wr_i;
   logic        line_start_i, pix_req_i, src_valid_i, src_ready_o, rgb_valid_o;
   logic [31:0] reg_addr_i, reg_wdata_i, reg_rdata_o, bar_wdata_i, bar_rdata_o, rd, w, cv;
   logic [3:0]  reg_be_i;
   logic [1:0]  c;
   logic [7:0]  src_byte_i;
   logic [23:0] rgb_o, gfx_pixel_i;
   logic [15:0] gfx_pixel16_o;
   int          fails, comparisons, n;

   via_if via_if_inst ();
   via_host via_host_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .vif(via_if_inst),
      .src_byte_i(src_byte_i), .src_valid_i(src_valid_i), .src_ready_o(src_ready_o));
   via_device via_device_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .vif(via_if_inst),
      .reg_addr_i(reg_addr_i), .reg_be_i(reg_be_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .bar_wr_i(bar_wr_i), .bar_wdata_i(bar_wdata_i), .bar_rdata_o(bar_rdata_o),
      .line_start_i(line_start_i), .pix_req_i(pix_req_i), .rgb_o(rgb_o),
      .rgb_valid_o(rgb_valid_o), .gfx_pixel_i(gfx_pixel_i), .gfx_pixel16_o(gfx_pixel16_o));
   via_assertions via_assertions_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
      .video_port_clock(via_if_inst.video_port_clock),
      .video_byte_valid(via_if_inst.video_byte_valid),
      .video_byte_bus(via_if_inst.video_byte_bus),
      .line_buffer_ready(via_if_inst.line_buffer_ready));

   // --------------------------------------------------------------------
   // Clock, watchdog and verdict
   // --------------------------------------------------------------------
   initial begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end
   initial begin
      #(25 * 20000);
      fails++;
      finish_test();
   end
   task automatic finish_test();
      if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // --------------------------------------------------------------------
   // Access tasks
   // --------------------------------------------------------------------
   // Inputs move 1 ns after the edge so the design samples settled values
   task automatic tick();
      @(posedge core_clk_i);
      #1;
   endtask
   task automatic do_reset();
      nrst_i = 1'b0;
      repeat (3) @(posedge core_clk_i);
      #1 nrst_i = 1'b1;
      tick();
   endtask
   task automatic reg_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_be_i = be;
      reg_wr_i = 1'b1;
      tick();
      reg_wr_i = 1'b0;
      tick();
   endtask
   task automatic reg_read(input logic [31:0] a);
      reg_addr_i = a;
      reg_be_i = 4'hf;
      reg_rd_i = 1'b1;
      tick();
      rd = reg_rdata_o;
      reg_rd_i = 1'b0;
      tick();
   endtask
   task automatic send(input logic [7:0] b);
      int k;
      src_byte_i = b;
      src_valid_i = 1'b1;
      k = 0;
      while (src_ready_o !== 1'b1 && k < 200) begin
         tick();
         k++;
      end
      `CHK("src_ready_o", 1'b1, src_ready_o)
      tick();
      src_valid_i = 1'b0;
      `CHK("video_byte_bus", b, via_if_inst.video_byte_bus)
      tick();
   endtask
   task automatic pix(input logic [23:0] ex);
      pix_req_i = 1'b1;
      tick();
      pix_req_i = 1'b0;
      `CHK("rgb_valid_o", 1'b1, rgb_valid_o)
      `CHK("rgb_o", ex, rgb_o)
      tick();
   endtask
   task automatic start_line();
      line_start_i = 1'b1;
      tick();
      line_start_i = 1'b0;
      tick();
   endtask
   // First listed byte goes first on the bus
   function automatic logic [31:0] order(input logic [1:0] f, input logic [7:0] y0, u, y1, v);
      case (f)
         2'b00:   return {u, y0, v, y1};
         2'b01:   return {y1, v, y0, u};
         2'b10:   return {y0, u, y1, v};
         default: return {y0, v, y1, u};
      endcase
   endfunction

   // --------------------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------------------
   initial begin
      {reg_wr_i, reg_rd_i, bar_wr_i, line_start_i, pix_req_i, src_valid_i} = 6'h00;
      {reg_addr_i, reg_wdata_i, bar_wdata_i, reg_be_i, src_byte_i} = '0;
      // Channels chosen so the dither bias never reaches the kept bits
      gfx_pixel_i = 24'h123450;
      fails = 0;
      comparisons = 0;
      // Bit 2 of f selects the sixteen-bit port mode
      for (int f = 0; f < 8; f++) begin
         do_reset();
         `CHK("bar_rdata_o", 32'h0, bar_rdata_o)
         bar_wdata_i = BASE | 32'habc;
         bar_wr_i = 1'b1;
         tick();
         bar_wr_i = 1'b0;
         tick();
         `CHK("bar_rdata_o", BASE, bar_rdata_o)
         if (f == 0) begin
            reg_read(BASE);
            `CHK("video_configuration", 32'h0, rd)
            reg_write(BASE, 32'hffff_ffff, 4'hf);
            reg_write(BASE, 32'h0, 4'h3);
            reg_write(32'h5000_0000, 32'h0, 4'hf);
            reg_read(BASE);
            `CHK("video_configuration", 32'h7bff_ffff, rd)
            reg_write(BASE + 32'h10, 32'hffff_ffff, 4'hf);
            reg_read(BASE + 32'h10);
            `CHK("video_scale_factors", 32'h3fff_3fff, rd)
            reg_read(BASE + 32'h20);
            `CHK("unmapped", 32'h0, rd)
         end
         reg_write(BASE + 32'h10, 32'h0000_2000, 4'hf);
         cv = 32'h0000_0101 | (32'(f[1:0]) << 2) | (32'(f[2]) << 29);
         reg_write(BASE, cv, 4'hf);
         `CHK("gfx_pixel16_o", f[2] ? 16'h11aa : 16'h0000, gfx_pixel16_o)
         // Sixteen-bit codes map onto the eight-bit orders; 00 and 11 act as 00
         c = !f[2] ? f[1:0] : (f[1:0] == 2'd1) ? 2'd2 : (f[1:0] == 2'd2) ? 2'd1 : 2'd0;
         w = order(c, 8'h80, 8'h80, 8'heb, 8'ha0);
         for (int i = 0; i < 4; i++) send(w[31 - 8 * i -: 8]);
         n = 0;
         do begin
            reg_read(BASE + 32'h40);
            n++;
         end while (rd[4] !== 1'b1 && n < 50);
         `CHK("line_full", 1'b1, rd[4])
         start_line();
         pix(24'hb66882);
         pix(24'hffe5ff);
         reg_write(BASE, cv | 32'h0000_0020, 4'hf);
         start_line();
         pix(24'h841000);
      end
      finish_test();
   end
endmodule
